/* include/csc_pkg.sv */
// Purpose: Shared constants and types for the charger register bank
// Assumes: 8-bit registers on a byte-wide register port
// Notes: Offsets are the register addresses of the serial interface
package csc_pkg;
    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h02;
    localparam logic [7:0] ADDR_CHG_STATUS = 8'h03;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h04;
    localparam logic [7:0] ADDR_VOLT_SEL = 8'h05;
    localparam logic [7:0] ADDR_SINK_CTRL = 8'h06;

    // ************************************************************
    // Values after reset or undervoltage lockout
    // ************************************************************
    localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_TIMER_CTRL = 8'h31;
    localparam logic [7:0] RST_VOLT_SEL = 8'hE0;
    localparam logic [7:0] RST_SINK_CTRL = 8'h64;

    // ************************************************************
    // Writable bits per register; the rest are read-only or reserved
    // ************************************************************
    localparam logic [7:0] WMASK_EVENT_FLAGS = 8'hE0;
    localparam logic [7:0] WMASK_TIMER_CTRL = 8'hFF;
    localparam logic [7:0] WMASK_VOLT_SEL = 8'hF0;
    localparam logic [7:0] WMASK_SINK_CTRL = 8'hFD;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int EV_MASK_INPUT = 7;
    localparam int EV_MASK_TOUCH = 6;
    localparam int EV_MASK_PB = 5;
    localparam int EV_TOUCH = 3;
    localparam int EV_PB = 2;
    localparam int EV_APPLIED = 1;
    localparam int EV_REMOVED = 0;
    localparam int TC_TIMER_SEL_HI = 7;
    localparam int TC_TIMER_SEL_LO = 6;
    localparam int TC_SAFETY_EN = 5;
    localparam int TC_SENSOR_TYPE = 4;
    localparam int TC_CHG_RESET = 3;
    localparam int TC_TERM_DIS = 2;
    localparam int TC_SUSPEND = 1;
    localparam int TC_CHG_EN = 0;
    localparam int VS_DYN_TIMER = 7;
    localparam int VS_PRECHG_HI = 6;
    localparam int VS_CHG_V_HI = 5;
    localparam int VS_CHG_V_LO = 4;
    localparam int SC_SINK_DIS_AC = 7;
    localparam int SC_PATH_TH_HI = 6;
    localparam int SC_PATH_TH_LO = 5;
    localparam int SC_PRECHG_LONG = 4;
    localparam int SC_TERM_F_HI = 3;
    localparam int SC_TERM_F_LO = 2;
    localparam int SC_CHG_ACTIVE = 1;
    localparam int SC_SINK_DIS_USB = 0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int TIMER_TICK_HZ = 1;
    localparam int TIMER_TICK_CYCLES = CLK_HZ / TIMER_TICK_HZ;
    // Timeouts in minutes; fast ones indexed by the timer select field, precharge picked by the long precharge bit
    localparam logic [9:0] FAST_TIMEOUT_MIN_0 = 10'd240;
    localparam logic [9:0] FAST_TIMEOUT_MIN_1 = 10'd300;
    localparam logic [9:0] FAST_TIMEOUT_MIN_2 = 10'd360;
    localparam logic [9:0] FAST_TIMEOUT_MIN_3 = 10'd480;
    localparam logic [9:0] PRECHG_TIMEOUT_SHORT_MIN = 10'd30;
    localparam logic [9:0] PRECHG_TIMEOUT_LONG_MIN = 10'd60;

    // ************************************************************
    // Live charger state reported by the analog loops
    // ************************************************************
    typedef struct packed {
        logic thermal_regulation;
        logic path_power_loop_active;
        logic thermal_suspend;
        logic term_current_reached;
        logic charge_timeout;
        logic precharge_timeout;
        logic battery_thermistor_error;
        logic charger_active;
    } csc_status_t;

    // Configuration driven to the charger core
    typedef struct packed {
        logic charger_enable;
        logic termination_allowed;
        logic sensor_type;
        logic precharge_high_level;
        logic [1:0] charge_voltage_sel;
        logic [1:0] path_power_threshold_sel;
        logic [1:0] term_current_factor_sel;
        logic [9:0] fast_timeout_min;
        logic [9:0] precharge_timeout_min;
    } csc_config_t;
endpackage

/* design/csc_regs.sv */
// Purpose: Charger configuration, status and event flag register bank
// Assumes: Register port driven by the serial protocol engine
// Notes: Undervoltage lockout reloads every register like reset
`timescale 1ns/1ps

module csc_regs
    import csc_pkg::*;
#(
    parameter int TICK_CYCLES = TIMER_TICK_CYCLES,
    parameter bit PB_ACTIVE_HIGH = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic undervoltage_lockout,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Event sources
    input wire logic pushbutton_input,
    input wire logic touch_panel_unit_touch,
    input wire logic ac_present,
    input wire logic usb_present,
    input wire csc_status_t charger_status_in,
    // Interrupt pin, open drain, active low
    output logic int_n_out,
    output logic int_n_oe,
    // Charger core controls
    output csc_config_t charger_config,
    output logic charger_restart,
    output logic timer_count_tick,
    output logic timer_clear,
    output logic sink_ac_enable,
    output logic sink_usb_enable
);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [7:0] event_r;
    logic [7:0] timer_ctrl_r;
    logic [7:0] volt_sel_r;
    logic [7:0] sink_ctrl_r;
    logic ac_d_r;
    logic usb_d_r;
    logic [7:0] rd_value;
    logic reload;
    logic wr_event;
    logic wr_timer;
    logic wr_volt;
    logic wr_sink;
    logic rd_event_clear;
    logic pb_active;
    logic touch_set;
    logic pb_set;
    logic applied_set;
    logic removed_set;

    assign reload = rst | undervoltage_lockout;
    assign wr_event = reg_wr && (reg_addr == ADDR_EVENT_FLAGS);
    assign wr_timer = reg_wr && (reg_addr == ADDR_TIMER_CTRL);
    assign wr_volt = reg_wr && (reg_addr == ADDR_VOLT_SEL);
    assign wr_sink = reg_wr && (reg_addr == ADDR_SINK_CTRL);
    assign rd_event_clear = reg_rd && (reg_addr == ADDR_EVENT_FLAGS);

    // Merge a write into a register, keeping read-only bits
    function automatic logic [7:0] merge_write(
        input logic [7:0] old_value,
        input logic [7:0] wdata,
        input logic [7:0] wmask
    );
        merge_write = (old_value & ~wmask) | (wdata & wmask);
    endfunction

    // ************************************************************
    // Event detection
    // ************************************************************
    assign pb_active = PB_ACTIVE_HIGH ? pushbutton_input
                                      : ~pushbutton_input;
    assign touch_set = touch_panel_unit_touch;
    assign pb_set = pb_active;
    assign applied_set = (ac_present & ~ac_d_r)
                       | (usb_present & ~usb_d_r);
    assign removed_set = (~ac_present & ac_d_r)
                       | (~usb_present & usb_d_r);

    always_ff @(posedge clock) begin
        if (reload) begin
            ac_d_r <= 1'b0;
            usb_d_r <= 1'b0;
        end else begin
            ac_d_r <= ac_present;
            usb_d_r <= usb_present;
        end
    end

    // ************************************************************
    // Event flags and masks
    // ************************************************************
    // A read clears the flags it returned; a set in the same cycle wins
    always_ff @(posedge clock) begin
        if (reload) begin
            event_r <= RST_EVENT_FLAGS;
        end else begin
            if (wr_event) begin
                event_r[7:5] <= reg_wdata[7:5];
            end
            event_r[4] <= 1'b0;
            event_r[EV_TOUCH] <= touch_set
                | (event_r[EV_TOUCH] & ~rd_event_clear);
            event_r[EV_PB] <= pb_set
                | (event_r[EV_PB] & ~rd_event_clear);
            event_r[EV_APPLIED] <= applied_set
                | (event_r[EV_APPLIED] & ~rd_event_clear);
            event_r[EV_REMOVED] <= removed_set
                | (event_r[EV_REMOVED] & ~rd_event_clear);
        end
    end

    // ************************************************************
    // Interrupt pin
    // ************************************************************
    // Pin only ever pulls low; the enable carries the level
    always_ff @(posedge clock) begin
        if (reload) begin
            int_n_out <= 1'b0;
            int_n_oe <= 1'b0;
        end else begin
            int_n_out <= 1'b0;
            int_n_oe <= (event_r[EV_MASK_PB] & event_r[EV_PB])
                | (event_r[EV_MASK_INPUT]
                   & (event_r[EV_APPLIED] | event_r[EV_REMOVED]))
                | (event_r[EV_MASK_TOUCH] & event_r[EV_TOUCH]);
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge clock) begin
        if (reload) begin
            timer_ctrl_r <= RST_TIMER_CTRL;
        end else if (wr_timer) begin
            timer_ctrl_r <= merge_write(timer_ctrl_r, reg_wdata,
                                        WMASK_TIMER_CTRL);
        end
    end

    always_ff @(posedge clock) begin
        if (reload) begin
            volt_sel_r <= RST_VOLT_SEL;
        end else if (wr_volt) begin
            volt_sel_r <= merge_write(volt_sel_r, reg_wdata,
                                      WMASK_VOLT_SEL);
        end
    end

    // Charger-active bit is live status, never stored
    always_ff @(posedge clock) begin
        if (reload) begin
            sink_ctrl_r <= RST_SINK_CTRL & WMASK_SINK_CTRL;
        end else if (wr_sink) begin
            sink_ctrl_r <= merge_write(sink_ctrl_r, reg_wdata,
                                       WMASK_SINK_CTRL) & WMASK_SINK_CTRL;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        rd_value = 8'h00;
        unique case (reg_addr)
            ADDR_EVENT_FLAGS: rd_value = event_r;
            ADDR_CHG_STATUS: begin
                rd_value[7] = charger_status_in.thermal_regulation;
                rd_value[6] = charger_status_in.path_power_loop_active;
                rd_value[5] = charger_status_in.thermal_suspend;
                rd_value[4] = charger_status_in.term_current_reached;
                rd_value[3] = 1'b0;
                rd_value[2] = charger_status_in.charge_timeout;
                rd_value[1] = charger_status_in.precharge_timeout;
                rd_value[0] =
                    charger_status_in.battery_thermistor_error;
            end
            ADDR_TIMER_CTRL: rd_value = timer_ctrl_r;
            ADDR_VOLT_SEL: rd_value = volt_sel_r & WMASK_VOLT_SEL;
            ADDR_SINK_CTRL: begin
                rd_value = sink_ctrl_r;
                rd_value[SC_CHG_ACTIVE] = charger_status_in.charger_active;
            end
            default: rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reload) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_value;
            end
        end
    end

    // ************************************************************
    // Decoded charger configuration
    // ************************************************************
    function automatic logic [9:0] fast_timeout(input logic [1:0] sel);
        unique case (sel)
            2'h0: fast_timeout = FAST_TIMEOUT_MIN_0;
            2'h1: fast_timeout = FAST_TIMEOUT_MIN_1;
            2'h2: fast_timeout = FAST_TIMEOUT_MIN_2;
            2'h3: fast_timeout = FAST_TIMEOUT_MIN_3;
        endcase
    endfunction

    always_ff @(posedge clock) begin
        if (reload) begin
            charger_config <= '0;
        end else begin
            // Toggling enable alone never pulses the restart
            charger_config.charger_enable <= timer_ctrl_r[TC_CHG_EN];
            charger_config.termination_allowed <=
                ~timer_ctrl_r[TC_TERM_DIS];
            charger_config.sensor_type <= timer_ctrl_r[TC_SENSOR_TYPE];
            charger_config.precharge_high_level <=
                volt_sel_r[VS_PRECHG_HI];
            charger_config.charge_voltage_sel <=
                volt_sel_r[VS_CHG_V_HI:VS_CHG_V_LO];
            charger_config.path_power_threshold_sel <=
                sink_ctrl_r[SC_PATH_TH_HI:SC_PATH_TH_LO];
            charger_config.term_current_factor_sel <=
                sink_ctrl_r[SC_TERM_F_HI:SC_TERM_F_LO];
            charger_config.fast_timeout_min <= fast_timeout(
                timer_ctrl_r[TC_TIMER_SEL_HI:TC_TIMER_SEL_LO]);
            charger_config.precharge_timeout_min <=
                sink_ctrl_r[SC_PRECHG_LONG] ? PRECHG_TIMEOUT_LONG_MIN
                                            : PRECHG_TIMEOUT_SHORT_MIN;
        end
    end

    // ************************************************************
    // Charger restart on set-then-clear of the reset bit
    // ************************************************************
    logic chg_reset_d_r;

    always_ff @(posedge clock) begin
        if (reload) begin
            chg_reset_d_r <= 1'b0;
            charger_restart <= 1'b0;
        end else begin
            chg_reset_d_r <= timer_ctrl_r[TC_CHG_RESET];
            charger_restart <= chg_reset_d_r
                & ~timer_ctrl_r[TC_CHG_RESET];
        end
    end

    // ************************************************************
    // Safety timer time base
    // ************************************************************
    // Counter is wide enough for the full default period
    logic [23:0] tick_cnt_r;
    logic tick_nominal;
    logic half_phase_r;
    logic slow_rate;
    logic timers_run;
    logic both_removed;

    assign tick_nominal =
        (tick_cnt_r == 24'(TICK_CYCLES - 1));
    assign slow_rate = volt_sel_r[VS_DYN_TIMER]
        & (charger_status_in.thermal_regulation
           | charger_status_in.path_power_loop_active);
    assign timers_run = timer_ctrl_r[TC_SAFETY_EN]
        & ~timer_ctrl_r[TC_SUSPEND];
    assign both_removed = ~ac_present & ~usb_present;

    always_ff @(posedge clock) begin
        if (reload || tick_nominal) begin
            tick_cnt_r <= 24'h000000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 24'h000001;
        end
    end

    always_ff @(posedge clock) begin
        if (reload) begin
            half_phase_r <= 1'b0;
        end else if (tick_nominal) begin
            half_phase_r <= ~half_phase_r;
        end
    end

    always_ff @(posedge clock) begin
        if (reload) begin
            timer_count_tick <= 1'b0;
            timer_clear <= 1'b0;
        end else begin
            timer_count_tick <= tick_nominal & timers_run & ~both_removed
                & (~slow_rate | half_phase_r);
            timer_clear <= both_removed;
        end
    end

    // ************************************************************
    // Input pull-down sinks
    // ************************************************************
    always_ff @(posedge clock) begin
        if (reload) begin
            sink_ac_enable <= 1'b0;
            sink_usb_enable <= 1'b0;
        end else begin
            sink_ac_enable <= ~sink_ctrl_r[SC_SINK_DIS_AC]
                & ~ac_present;
            sink_usb_enable <= ~sink_ctrl_r[SC_SINK_DIS_USB]
                & ~usb_present;
        end
    end

endmodule

/* verif/csc_host.sv */
// Purpose: Host model driving the byte register port
// Assumes: Strobes change only at the falling clock edge
// Notes: Write data shows an inverted pattern when idle
`timescale 1ns/1ps

module csc_host (
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'hA5;
        reg_rd = 1'b0;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        // Stale data would hide a late capture
        reg_wdata = ~v;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
        output logic ok);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 3; i++) begin
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                ok = 1'b1;
                break;
            end
            @(negedge clock);
        end
    endtask
endmodule

/* verif/csc_regs_checker.sv */
// Purpose: Port-level assertions for the charger register bank
// Assumes: Tick period of 8 cycles
// Notes: Both reset inputs disable every check
`timescale 1ns/1ps

module csc_regs_checker
    import csc_pkg::*;
#(
    parameter int TICK_CYCLES = TIMER_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic undervoltage_lockout,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic pushbutton_input,
    input wire logic touch_panel_unit_touch,
    input wire logic ac_present,
    input wire logic usb_present,
    input wire csc_status_t charger_status_in,
    input wire logic int_n_out,
    input wire logic int_n_oe,
    input wire csc_config_t charger_config,
    input wire logic charger_restart,
    input wire logic timer_count_tick,
    input wire logic timer_clear,
    input wire logic sink_ac_enable,
    input wire logic sink_usb_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || undervoltage_lockout);

    a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe got no answer");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without a read");
    a_rdata_hold: assert property (!reg_rvalid
        && !$past(rst || undervoltage_lockout) |-> $stable(reg_rdata))
        else $error("read data moved between reads");
    a_int_low_only: assert property (int_n_out == 1'b0)
        else $error("interrupt pin driven high");
    a_restart_pulse: assert property (charger_restart |=> !charger_restart)
        else $error("restart longer than one cycle");
    a_restart_source: assert property (charger_restart |->
        ($past(reg_wr, 2) && $past(reg_addr, 2) == ADDR_TIMER_CTRL) ||
        ($past(reg_wr, 3) && $past(reg_addr, 3) == ADDR_TIMER_CTRL))
        else $error("restart without a timer control write");
    a_sink_ac_off: assert property (ac_present |=> !sink_ac_enable)
        else $error("ac sink on while powered");
    a_sink_usb_off: assert property (usb_present |=> !sink_usb_enable)
        else $error("usb sink on while powered");
    a_clear_absent: assert property (!ac_present && !usb_present |=> timer_clear)
        else $error("timers not cleared without inputs");
    a_clear_present: assert property (ac_present || usb_present |=> !timer_clear)
        else $error("timers cleared with an input present");
    a_tick_absent: assert property ((!ac_present && !usb_present)[*2]
        |=> !timer_count_tick)
        else $error("timer ticking without inputs");
    a_tick_gap: assert property (timer_count_tick |=> !timer_count_tick[*7])
        else $error("timer ticks too close");
endmodule

/* verif/csc_regs_bench.sv */
// Purpose: Self-checking bench for the charger register bank
// Assumes: Host model owns the register port
// Notes: Tick period shortened to 8 cycles
`timescale 1ns/1ps

module csc_regs_bench;
    import csc_pkg::*;
    localparam int TICK_CYCLES = 8;
    logic clock, rst, undervoltage_lockout, reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, s8, e8, d;
    logic pushbutton_input, touch_panel_unit_touch, ac_present, usb_present;
    logic int_n_out, int_n_oe, charger_restart, timer_count_tick, ok;
    logic timer_clear, sink_ac_enable, sink_usb_enable;
    csc_status_t charger_status_in;
    csc_config_t charger_config;
    int mismatches = 0, compares = 0, n;
    logic [9:0] fast_tab [4] = '{10'd240, 10'd300, 10'd360, 10'd480};

    csc_regs #(.TICK_CYCLES(TICK_CYCLES), .PB_ACTIVE_HIGH(1'b0)) DUT (
        .clock(clock), .rst(rst), .undervoltage_lockout(undervoltage_lockout),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pushbutton_input(pushbutton_input),
        .touch_panel_unit_touch(touch_panel_unit_touch),
        .ac_present(ac_present), .usb_present(usb_present),
        .charger_status_in(charger_status_in), .int_n_out(int_n_out),
        .int_n_oe(int_n_oe), .charger_config(charger_config),
        .charger_restart(charger_restart), .timer_count_tick(timer_count_tick),
        .timer_clear(timer_clear), .sink_ac_enable(sink_ac_enable),
        .sink_usb_enable(sink_usb_enable));

    csc_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    // ********************
    // Shared tasks
    // ********************
    task automatic end_of_test();
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] s,
        input logic [33:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_host.write_reg(a, v);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_host.read_reg(a, d, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
        chk($sformatf("register %h", a), d, e);
    endtask

    task automatic ticks(input int e);
        n = 0;
        cyc(4);
        repeat (64) begin
            @(posedge clock);
            #1;
            if (timer_count_tick === 1'b1) n++;
        end
        @(negedge clock);
        chk("tick count", n, e);
    endtask

    task automatic restart_seen(input logic e);
        ok = 1'b0;
        repeat (6) begin
            @(posedge clock);
            #1;
            if (charger_restart === 1'b1) ok = 1'b1;
        end
        @(negedge clock);
        chk("restart pulse", ok, e);
    endtask

    task automatic press();
        pushbutton_input = 1'b0;
        cyc(1);
        pushbutton_input = 1'b1;
        cyc(3);
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ********************
    // Main sequence
    // ********************
    initial begin
        rst = 1'b1;
        undervoltage_lockout = 1'b0;
        pushbutton_input = 1'b1;
        touch_panel_unit_touch = 1'b0;
        ac_present = 1'b0;
        usb_present = 1'b0;
        charger_status_in = 8'h00;
        cyc(5);
        rst = 1'b0;
        rd(ADDR_EVENT_FLAGS, 8'h00);
        rd(ADDR_TIMER_CTRL, 8'h31);
        rd(ADDR_VOLT_SEL, 8'hE0);
        rd(ADDR_SINK_CTRL, 8'h64);
        rd(8'h07, 8'h00);
        chk("cfg", charger_config, {4'hF, 6'h2D, 10'd240, 10'd30});
        chk("sink ac", sink_ac_enable, 1'b1);
        for (int k = 0; k < 8; k++) begin
            s8 = 8'h01 << k;
            charger_status_in = s8;
            e8 = {s8[7:4], 1'b0, s8[3:1]};
            rd(ADDR_CHG_STATUS, e8);
            rd(ADDR_SINK_CTRL, 8'h64 | {6'h00, s8[0], 1'b0});
        end
        wr(ADDR_CHG_STATUS, 8'hFF);
        charger_status_in = 8'h00;
        rd(ADDR_CHG_STATUS, 8'h00);
        ac_present = 1'b1;
        cyc(2);
        rd(ADDR_EVENT_FLAGS, 8'h02);
        rd(ADDR_EVENT_FLAGS, 8'h00);
        chk("sink ac", sink_ac_enable, 1'b0);
        ac_present = 1'b0;
        cyc(2);
        rd(ADDR_EVENT_FLAGS, 8'h01);
        touch_panel_unit_touch = 1'b1;
        cyc(1);
        touch_panel_unit_touch = 1'b0;
        cyc(1);
        rd(ADDR_EVENT_FLAGS, 8'h08);
        rd(ADDR_EVENT_FLAGS, 8'h00);
        press();
        rd(ADDR_EVENT_FLAGS, 8'h04);
        // ********************
        // Interrupt masking
        // ********************
        wr(ADDR_EVENT_FLAGS, 8'hFF);
        rd(ADDR_EVENT_FLAGS, 8'hE0);
        chk("int", int_n_oe, 1'b0);
        press();
        chk("int", int_n_oe, 1'b1);
        rd(ADDR_EVENT_FLAGS, 8'hE4);
        cyc(2);
        chk("int", int_n_oe, 1'b0);
        usb_present = 1'b1;
        cyc(3);
        chk("int", int_n_oe, 1'b1);
        rd(ADDR_EVENT_FLAGS, 8'hE2);
        chk("sink usb", sink_usb_enable, 1'b0);
        wr(ADDR_EVENT_FLAGS, 8'h00);
        usb_present = 1'b0;
        press();
        chk("int", int_n_oe, 1'b0);
        rd(ADDR_EVENT_FLAGS, 8'h05);
        // ********************
        // Configuration decode
        // ********************
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_TIMER_CTRL, {k[1:0], 6'h31});
            cyc(2);
            chk("fast", charger_config.fast_timeout_min, fast_tab[k]);
        end
        wr(ADDR_TIMER_CTRL, 8'h35);
        cyc(2);
        chk("term", charger_config.termination_allowed, 1'b0);
        wr(ADDR_TIMER_CTRL, 8'h39);
        wr(ADDR_TIMER_CTRL, 8'h31);
        restart_seen(1'b1);
        wr(ADDR_TIMER_CTRL, 8'h30);
        cyc(2);
        chk("enable", charger_config.charger_enable, 1'b0);
        wr(ADDR_TIMER_CTRL, 8'h31);
        restart_seen(1'b0);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_VOLT_SEL, {2'b10, k[1:0], 4'hF});
            cyc(2);
            chk("chg v", charger_config.charge_voltage_sel, k[1:0]);
            chk("pre v", charger_config.precharge_high_level, 1'b0);
            rd(ADDR_VOLT_SEL, {2'b10, k[1:0], 4'h0});
        end
        wr(ADDR_SINK_CTRL, 8'h75);
        cyc(2);
        chk("pre t", charger_config.precharge_timeout_min, 10'd60);
        chk("sink usb", sink_usb_enable, 1'b0);
        wr(ADDR_SINK_CTRL, 8'hFF);
        cyc(2);
        chk("sink ac", sink_ac_enable, 1'b0);
        rd(ADDR_SINK_CTRL, 8'hFD);
        // ********************
        // Timer time base
        // ********************
        ac_present = 1'b1;
        ticks(8);
        charger_status_in = 8'h80;
        ticks(4);
        wr(ADDR_VOLT_SEL, 8'h60);
        ticks(8);
        charger_status_in = 8'h00;
        wr(ADDR_TIMER_CTRL, 8'h11);
        ticks(0);
        wr(ADDR_TIMER_CTRL, 8'h33);
        ticks(0);
        wr(ADDR_TIMER_CTRL, 8'h31);
        ac_present = 1'b0;
        ticks(0);
        chk("clear", timer_clear, 1'b1);
        // Lockout reloads like reset
        wr(ADDR_TIMER_CTRL, 8'h00);
        undervoltage_lockout = 1'b1;
        cyc(1);
        undervoltage_lockout = 1'b0;
        rd(ADDR_TIMER_CTRL, 8'h31);
        end_of_test();
    end
endmodule

bind csc_regs csc_regs_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clock(clock), .rst(rst), .undervoltage_lockout(undervoltage_lockout),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pushbutton_input(pushbutton_input),
    .touch_panel_unit_touch(touch_panel_unit_touch),
    .ac_present(ac_present), .usb_present(usb_present),
    .charger_status_in(charger_status_in), .int_n_out(int_n_out),
    .int_n_oe(int_n_oe), .charger_config(charger_config),
    .charger_restart(charger_restart), .timer_count_tick(timer_count_tick),
    .timer_clear(timer_clear), .sink_ac_enable(sink_ac_enable),
    .sink_usb_enable(sink_usb_enable));
